//--- pkg/dcwd_pkg.sv
// package for the configuration word decoder: register map, field layouts, encodings.
// assumes an apb bus with 32-bit data and one aligned word per register.
package dcwd_pkg;
    // register byte offsets
    localparam logic [7:0] DCWD_GEN_SEG_OFS = 8'h00;
    localparam logic [7:0] DCWD_OSC_SEL_OFS = 8'h04;
    localparam logic [7:0] DCWD_OSC_OFS = 8'h08;
    localparam logic [7:0] DCWD_WDT_OFS = 8'h0c;
    localparam logic [7:0] DCWD_AUX_SEG_OFS = 8'h10;
    localparam logic [7:0] DCWD_CTRL_OFS = 8'h14;
    localparam logic [7:0] DCWD_STATUS_OFS = 8'h18;
    // general segment field positions
    localparam int DCWD_GENERAL_WRITE_PROTECT_POS = 0;
    localparam int DCWD_GSS_POS = 1;
    localparam int DCWD_GKEY_POS = 2;
    // osc select field positions
    localparam int DCWD_NOSC_POS = 0;
    localparam int DCWD_TWO_SPEED_STARTUP_POS = 7;
    // osc field positions
    localparam int DCWD_POSC_POS = 0;
    localparam int DCWD_OSCIO_POS = 2;
    localparam int DCWD_L1WAY_POS = 5;
    localparam int DCWD_CKSM_POS = 6;
    // watchdog field position
    localparam int DCWD_WATCHDOG_CONFIG_POS = 7;
    // aux segment field positions
    localparam int DCWD_AUX_WRITE_PROTECT_POS = 0;
    localparam int DCWD_APL_POS = 1;
    localparam int DCWD_AKEY_POS = 2;
    // control register bits
    localparam int DCWD_CTRL_SWDT_POS = 0;
    localparam int DCWD_CTRL_PPSW_POS = 1;
    localparam int DCWD_CTRL_ERASE_POS = 2;
    // unprogrammed flash reads as ones
    localparam logic [7:0] DCWD_ERASED = 8'hff;
    localparam logic [1:0] DCWD_KEY_OPEN = 2'h0;
    localparam logic [1:0] DCWD_KEY_LOCK = 2'h3;

    typedef enum logic [2:0]
    {
        DCWD_NOSC_FRC = 3'b000,
        DCWD_NOSC_FRC_PLL = 3'b001,
        DCWD_NOSC_PRI = 3'b010,
        DCWD_NOSC_PRI_PLL = 3'b011,
        DCWD_NOSC_SEC = 3'b100,
        DCWD_NOSC_LOW_POWER_RC_OSCILLATOR = 3'b101,
        DCWD_NOSC_FRC_DIV16 = 3'b110,
        DCWD_NOSC_FRC_POST = 3'b111
    } dcwd_osc_e;

    typedef enum logic [1:0]
    {
        DCWD_POSC_EXT = 2'b00,
        DCWD_POSC_XTAL_MED = 2'b01,
        DCWD_POSC_XTAL_HS = 2'b10,
        DCWD_POSC_OFF = 2'b11
    } dcwd_posc_e;

    typedef enum logic [1:0]
    {
        DCWD_ST_RESET = 2'b00,
        DCWD_ST_FAST_RC = 2'b01,
        DCWD_ST_RUN = 2'b10
    } dcwd_start_e;

    // raw configuration fields as stored in nonvolatile memory
    typedef struct packed
    {
        logic [1:0] general_segment_key;
        logic general_code_protect;
        logic general_write_protect;
        logic two_speed_startup;
        logic [2:0] initial_osc_select;
        logic [1:0] clock_switch_monitor_mode;
        logic pin_select_lock_once;
        logic osc_pin_function;
        logic [1:0] primary_osc_mode;
        logic wdt_force_enable;
        logic [1:0] aux_segment_key;
        logic aux_code_protect;
        logic aux_write_protect;
    } dcwd_fields_s;

    // decoded settings handed to consumers
    typedef struct packed
    {
        logic code_protected;
        logic write_blocked;
        logic clk_switch_en;
        logic fail_safe_en;
        logic [1:0] posc_mode;
        logic xtal_mode;
        logic cfg_unlocked;
    } dcwd_settings_s;
endpackage

//--- logic/dcwd_sync.sv
// two-flop reset release synchroniser.
// assumes i_resetn may drop at any time; release is made synchronous to i_clock.
`timescale 1ns/100ps
module dcwd_sync
    import dcwd_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    output logic o_resetn
);
    logic stage1;
    logic next_stage1;
    logic next_out;

    always_comb
    begin
        next_stage1 = 1'b1;
        next_out = stage1;
    end

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            stage1 <= 1'b0;
            o_resetn <= 1'b0;
        end
        else
        begin
            stage1 <= next_stage1;
            o_resetn <= next_out;
        end
    end
endmodule

//--- logic/dcwd_decode.sv
// combinational decode of the active configuration fields into settings.
// assumes fields are stable registers; outputs are registered by the caller.
`timescale 1ns/100ps
module dcwd_decode
    import dcwd_pkg::*;
(
    input dcwd_fields_s i_fields,
    output dcwd_settings_s o_settings
);
    function automatic logic key_ok(input logic [1:0] key, input logic cp, input logic wp);
        key_ok = (cp && wp) ? (key == DCWD_KEY_OPEN) : (key == DCWD_KEY_LOCK);
    endfunction

    always_comb
    begin
        // key mismatch forces protection on
        o_settings.code_protected = !i_fields.general_code_protect ||
            !key_ok(i_fields.general_segment_key, i_fields.general_code_protect,
            i_fields.general_write_protect);
        o_settings.write_blocked = !i_fields.general_write_protect ||
            !key_ok(i_fields.general_segment_key, i_fields.general_code_protect,
            i_fields.general_write_protect);
        o_settings.clk_switch_en = !i_fields.clock_switch_monitor_mode[1];
        o_settings.fail_safe_en = (i_fields.clock_switch_monitor_mode == 2'b00);
        o_settings.posc_mode = i_fields.primary_osc_mode;
        o_settings.xtal_mode = (i_fields.primary_osc_mode == DCWD_POSC_XTAL_HS) ||
            (i_fields.primary_osc_mode == DCWD_POSC_XTAL_MED);
        o_settings.cfg_unlocked = i_fields.aux_code_protect && i_fields.aux_write_protect &&
            (i_fields.aux_segment_key == DCWD_KEY_OPEN) && i_fields.general_code_protect &&
            i_fields.general_write_protect &&
            (i_fields.general_segment_key == DCWD_KEY_OPEN);
    end
endmodule

//--- logic/dcwd_top.sv
// configuration word decoder: apb-visible nonvolatile configuration image and its decode.
// assumes a 40 MHz i_clock, apb master on the same clock, consumers sampling o_* levels.
// Functional notes
// - a key that does not match the protect bits turns general code protection on until erase.
// - general code-protect at 0 protects user program memory at once, at 1 leaves it open.
// - general write-protect at 0 blocks writes to user program memory at once, at 1 allows them.
// - two-speed start-up at 1 runs on fast rc until the chosen source is ready, at 0 not.
// - the 3-bit initial oscillator field selects one of eight sources by its fixed encoding.
// - with clock switching on, a new initial oscillator field acts only at the next reset.
// - clock switch mode 1x disables switching and monitor, 01 switching only, 00 both.
// - pin-select lock at 1 allows a single pin-mapping change, at 0 any number.
// - outside crystal modes the osc pin carries the clock when its bit is 1, else plain i/o.
// - primary mode 11 is off, 10 high-speed crystal, 01 medium crystal, 00 external clock.
// - watchdog force at 1 keeps watchdog and low-power rc on and ignores software clears.
// - watchdog force at 0 lets the software enable bit control watchdog and low-power rc.
// - configuration registers accept writes only with both segments fully unprotected.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module dcwd_top
    import dcwd_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic i_sel_osc_ready,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_code_protected,
    output logic o_write_blocked,
    output logic [2:0] o_active_osc,
    output logic o_clk_switch_en,
    output logic o_fail_safe_en,
    output logic [1:0] o_primary_osc_mode,
    output logic o_osc_pin_clock_out,
    output logic o_pin_select_write_ok,
    output logic o_wdt_enable,
    output logic o_low_power_rc_oscillator_enable
);
    logic rst_n;
    logic ready_meta;
    logic ready_sync;
    dcwd_fields_s nv;
    dcwd_fields_s next_nv;
    dcwd_settings_s dec;
    logic [2:0] osc_latched;
    logic [2:0] next_osc_latched;
    dcwd_start_e start_state;
    dcwd_start_e next_start_state;
    logic wdt_soft;
    logic next_wdt_soft;
    logic pps_used;
    logic next_pps_used;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_pready;
    logic setup;
    logic wr;
    logic [2:0] osc_cur;

    dcwd_sync u_sync
    (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .o_resetn(rst_n)
    );

    dcwd_decode u_decode
    (
        .i_fields(nv),
        .o_settings(dec)
    );

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == DCWD_GEN_SEG_OFS) || (a == DCWD_OSC_SEL_OFS) ||
            (a == DCWD_OSC_OFS) || (a == DCWD_WDT_OFS) || (a == DCWD_AUX_SEG_OFS) ||
            (a == DCWD_CTRL_OFS) || (a == DCWD_STATUS_OFS);
    endfunction

    // source ready comes from another clock domain
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_meta <= 1'b0;
            ready_sync <= 1'b0;
        end
        else
        begin
            ready_meta <= i_sel_osc_ready;
            ready_sync <= ready_meta;
        end
    end

    // single-cycle access: setup marks a transfer, access phase completes it
    assign setup = i_psel && !i_penable;
    assign wr = i_psel && i_penable && o_pready && i_pwrite;

    always_comb
    begin
        next_nv = nv;
        next_wdt_soft = wdt_soft;
        next_pps_used = pps_used;
        next_pslverr = 1'b0;
        next_pready = setup;
        if (setup && !known_addr(i_paddr))
        begin
            next_pslverr = 1'b1;
        end
        // writes to the configuration image need both segments open
        if (setup && i_pwrite && dec.cfg_unlocked == 1'b0 && i_paddr != DCWD_CTRL_OFS &&
            i_paddr != DCWD_STATUS_OFS)
        begin
            next_pslverr = 1'b1;
        end
        if (wr && !o_pslverr)
        begin
            case (i_paddr)
                DCWD_GEN_SEG_OFS:
                begin
                    next_nv.general_write_protect = i_pwdata[DCWD_GENERAL_WRITE_PROTECT_POS];
                    next_nv.general_code_protect = i_pwdata[DCWD_GSS_POS];
                    next_nv.general_segment_key = i_pwdata[DCWD_GKEY_POS +: 2];
                end
                DCWD_OSC_SEL_OFS:
                begin
                    next_nv.initial_osc_select = i_pwdata[DCWD_NOSC_POS +: 3];
                    next_nv.two_speed_startup = i_pwdata[DCWD_TWO_SPEED_STARTUP_POS];
                end
                DCWD_OSC_OFS:
                begin
                    next_nv.primary_osc_mode = i_pwdata[DCWD_POSC_POS +: 2];
                    next_nv.osc_pin_function = i_pwdata[DCWD_OSCIO_POS];
                    next_nv.pin_select_lock_once = i_pwdata[DCWD_L1WAY_POS];
                    next_nv.clock_switch_monitor_mode = i_pwdata[DCWD_CKSM_POS +: 2];
                end
                DCWD_WDT_OFS:
                begin
                    next_nv.wdt_force_enable = i_pwdata[DCWD_WATCHDOG_CONFIG_POS];
                end
                DCWD_AUX_SEG_OFS:
                begin
                    next_nv.aux_write_protect = i_pwdata[DCWD_AUX_WRITE_PROTECT_POS];
                    next_nv.aux_code_protect = i_pwdata[DCWD_APL_POS];
                    next_nv.aux_segment_key = i_pwdata[DCWD_AKEY_POS +: 2];
                end
                DCWD_CTRL_OFS:
                begin
                    // forced watchdog ignores software clears
                    if (!nv.wdt_force_enable || i_pwdata[DCWD_CTRL_SWDT_POS])
                    begin
                        next_wdt_soft = i_pwdata[DCWD_CTRL_SWDT_POS];
                    end
                    // bulk erase is the only way out of a key lockout
                    if (i_pwdata[DCWD_CTRL_ERASE_POS])
                    begin
                        next_nv = dcwd_fields_s'({$bits(dcwd_fields_s){1'b1}});
                        next_nv.general_segment_key = DCWD_KEY_OPEN;
                        next_nv.aux_segment_key = DCWD_KEY_OPEN;
                        next_pps_used = 1'b0;
                    end
                    // a mapping change in the same write as an erase still counts
                    if (i_pwdata[DCWD_CTRL_PPSW_POS])
                    begin
                        next_pps_used = 1'b1;
                    end
                end
                default:
                begin
                    next_nv = nv;
                end
            endcase
        end
    end

    // the image is the nonvolatile store, loaded all ones at reset, keys included
    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv <= dcwd_fields_s'({$bits(dcwd_fields_s){1'b1}});
            wdt_soft <= 1'b0;
            pps_used <= 1'b0;
        end
        else
        begin
            nv <= next_nv;
            wdt_soft <= next_wdt_soft;
            pps_used <= next_pps_used;
        end
    end

    // the source choice is captured at reset and follows the field while switching is off; switching on freezes it until the next reset
    always_comb
    begin
        next_osc_latched = osc_latched;
        next_start_state = start_state;
        // switching on: field change waits for reset, else follows at once
        if (!dec.clk_switch_en)
        begin
            next_osc_latched = nv.initial_osc_select;
        end
        case (start_state)
            DCWD_ST_RESET:
            begin
                next_osc_latched = nv.initial_osc_select;
                next_start_state = nv.two_speed_startup ? DCWD_ST_FAST_RC : DCWD_ST_RUN;
            end
            DCWD_ST_FAST_RC:
            begin
                if (ready_sync)
                begin
                    next_start_state = DCWD_ST_RUN;
                end
            end
            DCWD_ST_RUN:
            begin
                next_start_state = DCWD_ST_RUN;
            end
            default:
            begin
                next_start_state = DCWD_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_latched <= DCWD_NOSC_FRC;
            start_state <= DCWD_ST_RESET;
        end
        else
        begin
            osc_latched <= next_osc_latched;
            start_state <= next_start_state;
        end
    end

    // two-speed start runs on fast rc first
    assign osc_cur = (start_state == DCWD_ST_RUN) ? osc_latched : DCWD_NOSC_FRC;

    always_comb
    begin
        next_prdata = 32'h0;
        if (setup && !i_pwrite)
        begin
            case (i_paddr)
                DCWD_GEN_SEG_OFS:
                    next_prdata = {28'h0, nv.general_segment_key, nv.general_code_protect,
                        nv.general_write_protect};
                DCWD_OSC_SEL_OFS:
                    next_prdata = {24'h0, nv.two_speed_startup, 4'h0, nv.initial_osc_select};
                DCWD_OSC_OFS:
                    next_prdata = {24'h0, nv.clock_switch_monitor_mode, nv.pin_select_lock_once,
                        2'h0, nv.osc_pin_function, nv.primary_osc_mode};
                DCWD_WDT_OFS:
                    next_prdata = {24'h0, nv.wdt_force_enable, 7'h0};
                DCWD_AUX_SEG_OFS:
                    next_prdata = {28'h0, nv.aux_segment_key, nv.aux_code_protect,
                        nv.aux_write_protect};
                DCWD_CTRL_OFS:
                    next_prdata = {30'h0, pps_used, wdt_soft};
                DCWD_STATUS_OFS:
                    next_prdata = {22'h0, start_state, osc_cur, dec.cfg_unlocked,
                        dec.write_blocked, dec.code_protected, dec.fail_safe_en,
                        dec.clk_switch_en};
                default:
                    next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_prdata <= 32'h0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_code_protected <= 1'b0;
            o_write_blocked <= 1'b0;
            o_active_osc <= DCWD_NOSC_FRC;
            o_clk_switch_en <= 1'b0;
            o_fail_safe_en <= 1'b0;
            o_primary_osc_mode <= DCWD_POSC_OFF;
            o_osc_pin_clock_out <= 1'b0;
            o_pin_select_write_ok <= 1'b0;
            o_wdt_enable <= 1'b0;
            o_low_power_rc_oscillator_enable <= 1'b0;
        end
        else
        begin
            o_prdata <= next_prdata;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
            o_code_protected <= dec.code_protected;
            o_write_blocked <= dec.write_blocked;
            o_active_osc <= osc_cur;
            o_clk_switch_en <= dec.clk_switch_en;
            o_fail_safe_en <= dec.fail_safe_en;
            o_primary_osc_mode <= dec.posc_mode;
            o_osc_pin_clock_out <= nv.osc_pin_function && !dec.xtal_mode;
            o_pin_select_write_ok <= !(nv.pin_select_lock_once && pps_used);
            o_wdt_enable <= nv.wdt_force_enable || wdt_soft;
            o_low_power_rc_oscillator_enable <= nv.wdt_force_enable || wdt_soft;
        end
    end
endmodule

//--- verification/dcwd_chk_sva.sv
// checker for the configuration word decoder: apb answers and decoded settings.
// assumes it is bound to dcwd_top and sees only that module's ports.
`timescale 1ns/100ps
module dcwd_chk_sva
    import dcwd_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input logic o_pready,
    input logic o_pslverr,
    input logic o_code_protected,
    input logic o_clk_switch_en,
    input logic o_fail_safe_en,
    input logic [1:0] o_primary_osc_mode,
    input logic o_osc_pin_clock_out,
    input logic o_wdt_enable,
    input logic o_low_power_rc_oscillator_enable
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_locked_write;
        s_setup ##0 (i_pwrite && i_paddr <= DCWD_AUX_SEG_OFS && o_code_protected);
    endsequence
    sequence s_bad_addr;
        s_setup ##0 (i_paddr > DCWD_STATUS_OFS || i_paddr[1:0] != 2'b00);
    endsequence
    // decoded fields may only move within three edges of a write
    property p_hold;
        !$past(i_psel && i_pwrite, 1) && !$past(i_psel && i_pwrite, 2)
            && !$past(i_psel && i_pwrite, 3) |-> $stable(o_primary_osc_mode)
            && $stable(o_clk_switch_en) && $stable(o_fail_safe_en);
    endproperty

    chk_apb_answer: assert property (s_setup |=> o_pready ##1 !o_pready)
        else $error("apb answer not a single cycle after setup");
    chk_locked_refuse: assert property (s_locked_write |=> o_pready && o_pslverr)
        else $error("write to locked configuration not refused");
    chk_unmapped_err: assert property (s_bad_addr |=> o_pready && o_pslverr)
        else $error("unmapped address not refused");
    chk_failsafe_switch: assert property (o_fail_safe_en |-> o_clk_switch_en)
        else $error("fail-safe monitor on without clock switching");
    chk_xtal_pin: assert property (
        o_osc_pin_clock_out |-> !(o_primary_osc_mode inside {2'b01, 2'b10}))
        else $error("clock output driven in a crystal mode");
    chk_wdt_low_power_rc_oscillator: assert property (o_wdt_enable |-> o_low_power_rc_oscillator_enable)
        else $error("watchdog on while its rc clock is off");
    chk_settings_hold: assert property (p_hold)
        else $error("decoded settings changed without a write");
    chk_off_switch: assert property (
        $rose(o_fail_safe_en) |-> o_clk_switch_en && $past(i_psel && i_pwrite, 2))
        else $error("fail-safe monitor rose without a write");
endmodule

bind dcwd_top dcwd_chk_sva dcwd_chk_sva_inst (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_code_protected(o_code_protected),
    .o_clk_switch_en(o_clk_switch_en), .o_fail_safe_en(o_fail_safe_en),
    .o_primary_osc_mode(o_primary_osc_mode), .o_osc_pin_clock_out(o_osc_pin_clock_out),
    .o_wdt_enable(o_wdt_enable), .o_low_power_rc_oscillator_enable(o_low_power_rc_oscillator_enable));

//--- verification/dcwd_prog.sv
// programmer model: apb master writing the configuration image.
// assumes its tasks are called only after reset has been released.
`timescale 1ns/100ps
module dcwd_prog
    import dcwd_pkg::*;
(
    input wire logic i_clock,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata
);
    initial
    begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end

    // leading edge keeps back-to-back calls from driving psel twice in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_penable <= 1'b0;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clock);
        o_penable <= 1'b1;
        // no local limit: the bench timeout ends a wait that never answers
        do
        begin
            @(posedge i_clock);
        end
        while (i_pready !== 1'b1);
        q = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // released address and data lines show the inverse, never a stale value
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask

    task automatic prog_gen(input logic cp, input logic wp, output logic e);
        logic [1:0] key;
        logic [31:0] q;
        key = (cp && wp) ? DCWD_KEY_OPEN : DCWD_KEY_LOCK;
        xfer(1'b1, DCWD_GEN_SEG_OFS, {28'h0, key, cp, wp}, q, e);
    endtask
endmodule

//--- verification/device_config_word_decoder_bench.sv
// self-checking bench for the configuration word decoder.
// assumes dcwd_top, the checker bind and the programmer model are compiled first.
`timescale 1ns/100ps
module device_config_word_decoder_bench
    import dcwd_pkg::*;
;
    logic clock, resetn, osc_ready, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, d;
    logic [31:0] pwdata, prdata, q, r;
    logic cprot, wblk, sw, fs, co, psok, wdt, low_power_rc_oscillator, e;
    logic [2:0] act_osc;
    logic [1:0] posc;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    dcwd_top dcwd_top_inst (.i_clock(clock), .i_resetn(resetn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_sel_osc_ready(osc_ready), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_code_protected(cprot), .o_write_blocked(wblk),
        .o_active_osc(act_osc), .o_clk_switch_en(sw), .o_fail_safe_en(fs),
        .o_primary_osc_mode(posc), .o_osc_pin_clock_out(co),
        .o_pin_select_write_ok(psok), .o_wdt_enable(wdt), .o_low_power_rc_oscillator_enable(low_power_rc_oscillator));
    dcwd_prog dcwd_prog_inst (.i_clock(clock), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata));

    initial
    begin
        clock = 1'b0;
        resetn = 1'b0;
        osc_ready = 1'b0;
    end
    always #12.5 clock = ~clock;

    task automatic results;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            results;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // {switching, fail-safe, clock out} from the clock word
    function automatic logic [2:0] exp_dec(input logic [7:0] w);
        return {!w[7], w[7:6] == 2'b00, w[2] && w[1:0] != 2'b01 && w[1:0] != 2'b10};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic xe);
        logic [31:0] t;
        logic ee;
        dcwd_prog_inst.xfer(1'b1, a, v, t, ee);
        chk(ee, xe);
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic erase;
        wr(DCWD_CTRL_OFS, 32'h4, 1'b0);
        settle;
    endtask
    task automatic do_reset;
        @(posedge clock);
        resetn <= 1'b0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
    endtask

    initial
    begin
        r = $urandom(32'h2f2c71ab);
        do_reset;
        chk(act_osc, 3'b000);
        chk(cprot, 1'b1);
        @(posedge clock);
        osc_ready <= 1'b1;
        settle;
        settle;
        chk(act_osc, 3'b111);
        wr(DCWD_OSC_OFS, 32'hc3, 1'b1);
        wr(8'h1c, 32'h0, 1'b1);
        erase;
        chk({cprot, wblk}, 2'b00);
        wr(DCWD_OSC_OFS, 32'hc3, 1'b0);
        for (int k = 0; k < 8; k++)
        begin
            wr(DCWD_OSC_SEL_OFS, k, 1'b0);
            settle;
            chk(act_osc, k);
        end
        wr(DCWD_OSC_OFS, 32'h43, 1'b0);
        wr(DCWD_OSC_SEL_OFS, 32'h2, 1'b0);
        settle;
        chk(act_osc, 3'b111);
        for (int i = 0; i < 16; i++)
        begin
            r = $urandom;
            d = {i[1:0], r[0], 2'b00, r[1], i[3:2]};
            wr(DCWD_OSC_OFS, {24'h0, d}, 1'b0);
            settle;
            chk({sw, fs, co}, exp_dec(d));
            chk(posc, d[1:0]);
            dcwd_prog_inst.xfer(1'b0, DCWD_OSC_OFS, 32'h0, q, e);
            chk({e, q[7:0] & 8'he7}, {1'b0, d & 8'he7});
        end
        wr(DCWD_OSC_OFS, 32'he3, 1'b0);
        settle;
        chk(psok, 1'b1);
        wr(DCWD_CTRL_OFS, 32'h2, 1'b0);
        settle;
        chk(psok, 1'b0);
        wr(DCWD_OSC_OFS, 32'hc3, 1'b0);
        wr(DCWD_CTRL_OFS, 32'h2, 1'b0);
        settle;
        chk(psok, 1'b1);
        wr(DCWD_CTRL_OFS, 32'h1, 1'b0);
        wr(DCWD_WDT_OFS, 32'h80, 1'b0);
        wr(DCWD_CTRL_OFS, 32'h0, 1'b0);
        settle;
        chk({wdt, low_power_rc_oscillator}, 2'b11);
        // the clear above must have been ignored, so the soft bit still holds
        wr(DCWD_WDT_OFS, 32'h0, 1'b0);
        settle;
        chk(wdt, 1'b1);
        wr(DCWD_CTRL_OFS, 32'h0, 1'b0);
        settle;
        chk(wdt, 1'b0);
        wr(DCWD_CTRL_OFS, 32'h1, 1'b0);
        settle;
        chk({wdt, low_power_rc_oscillator}, 2'b11);
        dcwd_prog_inst.prog_gen(1'b1, 1'b0, e);
        settle;
        chk({e, cprot, wblk}, 3'b001);
        wr(DCWD_OSC_OFS, 32'hc3, 1'b1);
        erase;
        dcwd_prog_inst.prog_gen(1'b0, 1'b1, e);
        settle;
        chk({e, cprot}, 2'b01);
        erase;
        wr(DCWD_GEN_SEG_OFS, 32'hf, 1'b0);
        settle;
        chk(cprot, 1'b1);
        erase;
        wr(DCWD_AUX_SEG_OFS, 32'hd, 1'b0);
        wr(DCWD_OSC_OFS, 32'hc3, 1'b1);
        erase;
        chk(cprot, 1'b0);
        do_reset;
        chk(cprot, 1'b1);
        results;
    end
endmodule
